// file: rtl/pcrs_top.sv
// Program counter, latches, 31-level return stack and fast shadow registers.
// Assumes the core issues at most one command per cycle on cmd, and that
// software reaches the registers over AXI4-Lite on the same clock.
`timescale 1ns/10ps

// Summary of operation
// - Program counter is 21 bits; fetches beyond implemented memory return zero.
// - Reset starts at 0000h; interrupts vector to 0008h or 0018h.
// - PC held as three bytes; high and upper only via latches.
// - Writing the low byte loads high and upper bytes from latches.
// - Reading the low byte copies high and upper bytes into latches.
// - PC bit 0 is zero unless a return loads an odd top entry written by software; sequential fetch adds two.
// - Call and jump load PC directly, latches unused.
// - Calls and interrupts push; returns pop; latches untouched.
// - Stack holds 31 entries of 21 bits, 5-bit pointer, private space.
// - Push increments pointer first, then writes the current PC.
// - Pop loads PC from addressed entry, then decrements pointer.
// - Every reset zeroes the pointer; value zero has no storage.
// - Top-entry registers read and write the currently addressed entry.
// - Full flag sets on 31st push; held until software or power-on clear.
// - With fault reset, 31st push stores PC+2, sets full, resets.
// - Without fault reset, pointer stays 31 and later pushes store nothing.
// - Empty pop returns zero, sets underflow, pointer stays zero.
// - Fault reset option: flag and device reset request on the same edge; otherwise flag only.
// - Software push stores PC; software pop only decrements the pointer.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4:0.
// - One-level shadow of status, working, bank on interrupt or fast call.
module pcrs_top
  import pcrs_pkg::*;
#(
  parameter int IMPL_BYTES = 98304
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                dev_reset,
  // Core command port
  input  wire pcrs_cmd_t           cmd,
  input  wire logic [PC_W-1:0]     cmd_addr,
  input  wire logic [7:0]          cmd_data,
  input  wire logic                cmd_fast,
  output logic                     cmd_ready,
  // Program memory fetch
  output logic [PC_W-1:0]          fetch_addr,
  input  wire logic [15:0]         mem_rdata,
  output logic [15:0]              fetch_word,
  output logic [7:0]               pc_low_rdata,
  // Fast shadow
  input  wire logic [STATUS_W-1:0] status_in,
  input  wire logic [WORKING_REGISTER_W-1:0]   working_register_in,
  input  wire logic [BSR_W-1:0]    bank_select_register_in,
  output logic [STATUS_W-1:0]      shadow_status,
  output logic [WORKING_REGISTER_W-1:0]        shadow_working_register,
  output logic [BSR_W-1:0]         shadow_bank_select_register,
  output logic                     shadow_restore,
  // Stack fault reset request
  output logic                     stack_fault_reset,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  initial begin
    if (IMPL_BYTES < 2 || IMPL_BYTES > (1 << PC_W)) begin
      $error("pcrs_top: IMPL_BYTES out of range");
    end
  end

  localparam logic [PC_W:0] IMPL_LIMIT = (PC_W + 1)'(IMPL_BYTES);

  logic [PC_W-1:0] pc;
  logic [7:0]      pc_high_latch;
  logic [4:0]      pc_upper_latch;
  logic [SP_W-1:0] return_stack_pointer;
  logic            stack_full_flag;
  logic            stack_underflow_flag;
  logic            stack_fault_reset_enable;
  logic [PC_W-1:0] stack_mem [1:STACK_DEPTH];

  logic            wr_go;
  logic            rd_go;
  logic            push_req;
  logic            pop_req;
  logic            overflow;
  logic            underflow;
  logic            fault;
  logic            pcl_wr;
  logic            pcl_rd;
  logic [7:0]      pcl_wr_data;
  logic [7:0]      wbyte;
  logic [PC_W-1:0] top_entry;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] next_pc;
  logic [31:0]     next_rdata;
  logic            rd_mapped;
  logic            wr_mapped;

  // Bus access only in idle command cycles, so software and core never collide
  assign cmd_ready     = 1'b1;
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && (cmd == PCRS_CMD_NONE);
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid && (cmd == PCRS_CMD_NONE);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wbyte         = s_axi_wdata[7:0];

  assign top_entry = (return_stack_pointer == SP_EMPTY) ? '0 : stack_mem[return_stack_pointer];
  assign fetch_addr = pc;

  always_comb begin
    push_req  = (cmd == PCRS_CMD_CALL) || (cmd == PCRS_CMD_INT_HIGH) ||
                (cmd == PCRS_CMD_INT_LOW) || (cmd == PCRS_CMD_SW_PUSH);
    pop_req   = (cmd == PCRS_CMD_RETURN) || (cmd == PCRS_CMD_SW_POP);
    overflow  = push_req && (return_stack_pointer >= SP_LAST_FREE);
    underflow = pop_req && (return_stack_pointer == SP_EMPTY);
    fault     = stack_fault_reset_enable && (overflow || underflow);
    // 31st push under fault reset saves the address after the call
    push_val  = (stack_fault_reset_enable && return_stack_pointer == SP_LAST_FREE)
              ? pc + PC_STEP : pc;
    pcl_wr      = (cmd == PCRS_CMD_PCL_WRITE) || (wr_go && s_axi_awaddr == OFF_PC_LOW && s_axi_wstrb[0]);
    pcl_wr_data = (cmd == PCRS_CMD_PCL_WRITE) ? cmd_data : wbyte;
    pcl_rd      = (cmd == PCRS_CMD_PCL_READ) || (rd_go && s_axi_araddr == OFF_PC_LOW);
  end

  always_comb begin
    next_pc = pc;
    case (cmd)
      PCRS_CMD_FETCH:     next_pc = pc + PC_STEP;
      PCRS_CMD_CALL:      next_pc = {cmd_addr[PC_W-1:1], 1'b0};
      PCRS_CMD_JUMP:      next_pc = {cmd_addr[PC_W-1:1], 1'b0};
      PCRS_CMD_INT_HIGH:  next_pc = VECTOR_HIGH;
      PCRS_CMD_INT_LOW:   next_pc = VECTOR_LOW;
      PCRS_CMD_RETURN:    next_pc = underflow ? RESET_VECTOR : top_entry;
      PCRS_CMD_PCL_WRITE: next_pc = {pc_upper_latch, pc_high_latch, cmd_data[7:1], 1'b0};
      default:            next_pc = pc;
    endcase
    if (wr_go && pcl_wr) begin
      next_pc = {pc_upper_latch, pc_high_latch, wbyte[7:1], 1'b0};
    end
    if (fault) begin
      next_pc = RESET_VECTOR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset) begin
      pc <= RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  // Latches change only by bus writes or low-byte reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_high_latch  <= '0;
      pc_upper_latch <= '0;
    end else if (pcl_rd) begin
      pc_high_latch  <= pc[15:8];
      pc_upper_latch <= pc[20:16];
    end else if (wr_go && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == OFF_HIGH_LATCH) begin
        pc_high_latch <= wbyte;
      end
      if (s_axi_awaddr == OFF_UPPER_LATCH) begin
        pc_upper_latch <= wbyte[4:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_low_rdata <= '0;
    end else if (cmd == PCRS_CMD_PCL_READ) begin
      pc_low_rdata <= pc[7:0];
    end
  end

  // Out-of-range fetches decode as no-operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_word <= '0;
    end else begin
      fetch_word <= ({1'b0, pc} >= IMPL_LIMIT) ? 16'h0000 : mem_rdata;
    end
  end

  // Entry 0 does not exist: the pointer value zero only marks empty
  always_ff @(posedge aclk) begin
    if (push_req && return_stack_pointer != SP_FULL && aresetn && !dev_reset) begin
      stack_mem[return_stack_pointer + 5'h01] <= push_val;
    end else if (wr_go && s_axi_wstrb[0] && return_stack_pointer != SP_EMPTY) begin
      case (s_axi_awaddr)
        OFF_TOP_LOW:   stack_mem[return_stack_pointer][7:0]   <= wbyte;
        OFF_TOP_HIGH:  stack_mem[return_stack_pointer][15:8]  <= wbyte;
        OFF_TOP_UPPER: stack_mem[return_stack_pointer][20:16] <= wbyte[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset || fault) begin
      return_stack_pointer <= SP_EMPTY;
    end else if (push_req) begin
      if (return_stack_pointer != SP_FULL) begin
        return_stack_pointer <= return_stack_pointer + 5'h01;
      end
    end else if (pop_req) begin
      if (return_stack_pointer != SP_EMPTY) begin
        return_stack_pointer <= return_stack_pointer - 5'h01;
      end
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFF_STACK_POINTER) begin
      return_stack_pointer <= wbyte[4:0];
    end
  end

  // Flags survive device resets; writing zero clears, a same-cycle event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else if (overflow || underflow) begin
      stack_full_flag      <= stack_full_flag | overflow;
      stack_underflow_flag <= stack_underflow_flag | underflow;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFF_STACK_POINTER) begin
      stack_full_flag      <= stack_full_flag & wbyte[FULL_BIT];
      stack_underflow_flag <= stack_underflow_flag & wbyte[UNDERFLOW_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_fault_reset_enable <= FAULT_EN_RESET;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFF_CONFIG) begin
      stack_fault_reset_enable <= wbyte[FAULT_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= fault;
    end
  end

  // One level only: a nested capture overwrites the earlier one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_status               <= '0;
      shadow_working_register     <= '0;
      shadow_bank_select_register <= '0;
    end else if (cmd == PCRS_CMD_INT_HIGH || cmd == PCRS_CMD_INT_LOW ||
                 (cmd == PCRS_CMD_CALL && cmd_fast)) begin
      shadow_status               <= status_in;
      shadow_working_register     <= working_register_in;
      shadow_bank_select_register <= bank_select_register_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_restore <= 1'b0;
    end else begin
      shadow_restore <= (cmd == PCRS_CMD_RETURN) && cmd_fast;
    end
  end

  always_comb begin
    wr_mapped = (s_axi_awaddr[7:2] <= OFF_CONFIG[7:2]) && (s_axi_awaddr[1:0] == 2'h0);
    rd_mapped = (s_axi_araddr[7:2] <= OFF_CONFIG[7:2]) && (s_axi_araddr[1:0] == 2'h0);
    next_rdata = 32'h00000000;
    case (s_axi_araddr)
      OFF_STACK_POINTER: next_rdata[7:0] = {stack_full_flag, stack_underflow_flag, 1'b0,
                                            return_stack_pointer};
      OFF_TOP_LOW:       next_rdata[7:0] = top_entry[7:0];
      OFF_TOP_HIGH:      next_rdata[7:0] = top_entry[15:8];
      OFF_TOP_UPPER:     next_rdata[4:0] = top_entry[20:16];
      OFF_PC_LOW:        next_rdata[7:0] = pc[7:0];
      OFF_HIGH_LATCH:    next_rdata[7:0] = pc_high_latch;
      OFF_UPPER_LATCH:   next_rdata[4:0] = pc_upper_latch;
      OFF_CONFIG:        next_rdata[0]   = stack_fault_reset_enable;
      default:           next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= next_rdata;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_push_free;
    push_req && return_stack_pointer < SP_LAST_FREE && !dev_reset;
  endsequence
  sequence s_empty_pop;
    underflow && !dev_reset;
  endsequence
  sequence s_idle;
    cmd == PCRS_CMD_NONE && !wr_go && !dev_reset;
  endsequence

  AST_PC_ALIGNED: assert property (pc[0] == 1'b0)
    else $error("pc bit 0 not zero");
  AST_FETCH_STEP: assert property (
    (cmd == PCRS_CMD_FETCH && !dev_reset) |=> pc == $past(pc) + PC_STEP)
    else $error("fetch did not advance pc by two");
  AST_INT_VECTOR: assert property (
    (cmd == PCRS_CMD_INT_HIGH && !fault && !dev_reset && return_stack_pointer != SP_FULL)
    |=> pc == VECTOR_HIGH && return_stack_pointer == $past(return_stack_pointer) + 5'h01)
    else $error("interrupt did not vector and push");
  AST_PCL_WRITE: assert property (
    (cmd == PCRS_CMD_PCL_WRITE && !dev_reset)
    |=> pc[20:8] == {$past(pc_upper_latch), $past(pc_high_latch)})
    else $error("low byte write did not load latches");
  AST_PUSH_POP: assert property (
    s_push_free ##1 s_idle ##1 s_idle ##1 (cmd == PCRS_CMD_RETURN && !dev_reset)
    |=> pc == $past(pc, 4) && return_stack_pointer == $past(return_stack_pointer, 4))
    else $error("return did not restore pushed address");
  AST_UNDERFLOW: assert property (
    s_empty_pop |=> stack_underflow_flag && return_stack_pointer == SP_EMPTY
    && pc == RESET_VECTOR)
    else $error("empty pop mishandled");
  AST_FULL_STUCK: assert property (
    (push_req && !stack_fault_reset_enable && !dev_reset && return_stack_pointer == SP_FULL)
    |=> return_stack_pointer == SP_FULL && stack_full_flag)
    else $error("push beyond full moved pointer");
  AST_FAULT_RESET: assert property (
    (overflow && stack_fault_reset_enable)
    |=> stack_fault_reset && stack_full_flag && return_stack_pointer == SP_EMPTY)
    else $error("overflow did not request reset");
  AST_SHADOW: assert property (
    (cmd == PCRS_CMD_INT_LOW) |=> shadow_working_register == $past(working_register_in))
    else $error("shadow not captured");

endmodule

// file: rtl/pcrs_pkg.sv
// Constants for the program counter and return stack block.
// Assumes a single core clock domain and an 8-bit data path toward the core.
package pcrs_pkg;
  localparam int          PC_W         = 21;
  localparam int          SP_W         = 5;
  localparam int          STACK_DEPTH  = 31;
  localparam int          STATUS_W     = 8;
  localparam int          WORKING_REGISTER_W       = 8;
  localparam int          BSR_W        = 4;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] VECTOR_HIGH  = 21'h000008;
  localparam logic [20:0] VECTOR_LOW   = 21'h000018;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [4:0]  SP_EMPTY     = 5'h00;
  localparam logic [4:0]  SP_LAST_FREE = 5'h1E;
  localparam logic [4:0]  SP_FULL      = 5'h1F;
  // Register byte addresses
  localparam logic [7:0]  OFF_STACK_POINTER = 8'h00;
  localparam logic [7:0]  OFF_TOP_LOW       = 8'h04;
  localparam logic [7:0]  OFF_TOP_HIGH      = 8'h08;
  localparam logic [7:0]  OFF_TOP_UPPER     = 8'h0C;
  localparam logic [7:0]  OFF_PC_LOW        = 8'h10;
  localparam logic [7:0]  OFF_HIGH_LATCH    = 8'h14;
  localparam logic [7:0]  OFF_UPPER_LATCH   = 8'h18;
  localparam logic [7:0]  OFF_CONFIG        = 8'h1C;
  // Field positions and reset values
  localparam int          FULL_BIT          = 7;
  localparam int          UNDERFLOW_BIT     = 6;
  localparam int          FAULT_EN_BIT      = 0;
  localparam logic        FAULT_EN_RESET    = 1'b1;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [3:0] {
    PCRS_CMD_NONE      = 4'h0,
    PCRS_CMD_FETCH     = 4'h1,
    PCRS_CMD_CALL      = 4'h2,
    PCRS_CMD_INT_HIGH  = 4'h3,
    PCRS_CMD_INT_LOW   = 4'h4,
    PCRS_CMD_RETURN    = 4'h5,
    PCRS_CMD_JUMP      = 4'h6,
    PCRS_CMD_SW_PUSH   = 4'h7,
    PCRS_CMD_SW_POP    = 4'h8,
    PCRS_CMD_PCL_WRITE = 4'h9,
    PCRS_CMD_PCL_READ  = 4'hA
  } pcrs_cmd_t;
endpackage

// file: tb/pcrs_core_model.sv
// Program memory answering the fetch port of the block.
// Assumes a combinational read of the word at the fetch address.
`timescale 1ns/10ps
module pcrs_core_model (
  // Fetch side
  input  wire logic [20:0] fetch_addr,
  output logic      [15:0] mem_rdata
);
  // Never all zeros, so a zero word can only come from the block
  assign mem_rdata = {fetch_addr[8:1], ~fetch_addr[8:1]};
endmodule

// file: tb/tb.sv
// Self-checking bench for the program counter and return stack block.
// Assumes one 100 MHz clock and the program memory model beside the block.
`timescale 1ns/10ps
module tb;
  import pcrs_pkg::*;
  localparam int IMPL = 512;
  logic             aclk, aresetn, dev_reset, cmd_fast, cmd_ready;
  pcrs_cmd_t        cmd, c;
  logic [PC_W-1:0]  cmd_addr, fetch_addr, pc_m, t;
  logic [PC_W-1:0]  stk [32];
  logic [7:0]       cmd_data, pc_low_rdata, status_in, working_register_in, hl_m, pl_m;
  logic [15:0]      mem_rdata, fetch_word;
  logic [3:0]       bank_select_register_in, s_axi_wstrb, shadow_bank_select_register;
  logic [7:0]       shadow_status, shadow_working_register, s_axi_awaddr, s_axi_araddr;
  logic             shadow_restore, stack_fault_reset, s_axi_awvalid, s_axi_awready;
  logic             s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rdat, seed;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]       sp_m, ul_m;
  logic [19:0]      sh_m;
  logic             full_m, unf_m, fen_m, flt_m, rst_m;
  int               miscompares, tests_run, i;
  pcrs_cmd_t        tbl [10] = '{PCRS_CMD_FETCH, PCRS_CMD_CALL, PCRS_CMD_INT_HIGH,
    PCRS_CMD_INT_LOW, PCRS_CMD_RETURN, PCRS_CMD_JUMP, PCRS_CMD_SW_PUSH, PCRS_CMD_SW_POP,
    PCRS_CMD_PCL_WRITE, PCRS_CMD_PCL_READ};

  pcrs_top #(.IMPL_BYTES(IMPL)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .dev_reset(dev_reset), .cmd(cmd), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_fast(cmd_fast), .cmd_ready(cmd_ready),
    .fetch_addr(fetch_addr), .mem_rdata(mem_rdata), .fetch_word(fetch_word),
    .pc_low_rdata(pc_low_rdata), .status_in(status_in),
    .working_register_in(working_register_in),
    .bank_select_register_in(bank_select_register_in), .shadow_status(shadow_status),
    .shadow_working_register(shadow_working_register),
    .shadow_bank_select_register(shadow_bank_select_register),
    .shadow_restore(shadow_restore), .stack_fault_reset(stack_fault_reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  pcrs_core_model u_mem (.fetch_addr(fetch_addr), .mem_rdata(mem_rdata));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready and valid are looked at mid-cycle, where they are settled for the next edge
  task automatic wait_resp(input logic ar);
    int   n;
    logic hs;
    n = 0;
    hs = 1'b0;
    while (!hs && n < 64) begin
      @(negedge aclk);
      hs = (ar ? s_axi_arready : (s_axi_awready && s_axi_wready)) === 1'b1;
      @(posedge aclk);
      n++;
    end
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs && n < 64) begin
      @(negedge aclk);
      hs = (ar ? s_axi_rvalid : s_axi_bvalid) === 1'b1;
      resp = ar ? s_axi_rresp : s_axi_bresp;
      rdat = s_axi_rdata;
      @(posedge aclk);
      n++;
    end
    if (!hs) begin
      chk("bus handshake", 0, 1);
      tally_and_finish();
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_resp(1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_resp(1'b1);
  endtask

  task automatic chk_sp();
    rd(OFF_STACK_POINTER);
    chk("stack pointer", rdat, {24'h0, full_m, unf_m, 1'b0, sp_m});
  endtask

  task automatic chk_top();
    logic [31:0] lo;
    logic [31:0] hi;
    rd(OFF_TOP_LOW);
    lo = rdat;
    rd(OFF_TOP_HIGH);
    hi = rdat;
    rd(OFF_TOP_UPPER);
    chk("top entry", {rdat, hi, lo}, {27'h0, stk[sp_m][20:16], 24'h0, stk[sp_m][15:8],
      24'h0, stk[sp_m][7:0]});
  endtask

  task automatic chk_latch();
    logic [31:0] hi;
    rd(OFF_HIGH_LATCH);
    hi = rdat;
    rd(OFF_UPPER_LATCH);
    chk("latches", {hi, rdat}, {24'h0, hl_m, 27'h0, ul_m});
  endtask

  task automatic push(input logic [PC_W-1:0] v);
    if (sp_m < SP_LAST_FREE) begin
      sp_m++;
      stk[sp_m] = v;
    end else begin
      full_m = 1'b1;
      if (sp_m == SP_LAST_FREE) stk[SP_FULL] = fen_m ? pc_m + PC_STEP : v;
      if (fen_m) begin
        {sp_m, pc_m, flt_m} = {5'h0, 21'h0, 1'b1};
      end else sp_m = SP_FULL;
    end
  endtask

  task automatic core(input pcrs_cmd_t k, input logic [PC_W-1:0] a, input logic f);
    logic [7:0] d;
    d = 8'(rnd());
    @(posedge aclk);
    cmd <= k;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_fast <= f;
    status_in <= d ^ 8'h3C;
    working_register_in <= ~d;
    bank_select_register_in <= d[3:0];
    flt_m = 1'b0;
    rst_m = f && k == PCRS_CMD_RETURN;
    if (k == PCRS_CMD_INT_HIGH || k == PCRS_CMD_INT_LOW || (k == PCRS_CMD_CALL && f))
      sh_m = {d ^ 8'h3C, ~d, d[3:0]};
    case (k)
      PCRS_CMD_FETCH: pc_m += PC_STEP;
      PCRS_CMD_CALL, PCRS_CMD_INT_HIGH, PCRS_CMD_INT_LOW, PCRS_CMD_SW_PUSH: begin
        push(pc_m);
        if (!flt_m && k != PCRS_CMD_SW_PUSH)
          pc_m = k == PCRS_CMD_CALL ? {a[20:1], 1'b0} :
                 k == PCRS_CMD_INT_HIGH ? VECTOR_HIGH : VECTOR_LOW;
      end
      PCRS_CMD_RETURN: begin
        if (sp_m == SP_EMPTY) {pc_m, unf_m, flt_m} = {21'h0, 1'b1, fen_m};
        else begin
          pc_m = stk[sp_m];
          sp_m--;
        end
      end
      PCRS_CMD_JUMP: pc_m = {a[20:1], 1'b0};
      PCRS_CMD_SW_POP: sp_m--;
      PCRS_CMD_PCL_WRITE: pc_m = {ul_m, hl_m, d[7:1], 1'b0};
      PCRS_CMD_PCL_READ: {ul_m, hl_m, pl_m} = pc_m;
      default: ;
    endcase
    @(posedge aclk);
    cmd <= PCRS_CMD_NONE;
    #1;
    chk("pc", fetch_addr, pc_m);
    chk("ready", cmd_ready, 1'b1);
    chk("shadow", {shadow_status, shadow_working_register, shadow_bank_select_register},
      sh_m);
    if (k == PCRS_CMD_PCL_READ) chk("pc low", pc_low_rdata, pl_m);
    chk("pulses", {stack_fault_reset, shadow_restore}, {flt_m, rst_m});
    @(posedge aclk);
    #1;
    chk("pulse end", {stack_fault_reset, shadow_restore}, 2'b00);
    chk("fetch word", fetch_word, pc_m < IMPL ? {pc_m[8:1], ~pc_m[8:1]} : 16'h0);
  endtask

  initial begin
    seed = 32'hA845CDD2;
    {aresetn, dev_reset, cmd_fast, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {cmd_addr, cmd_data, status_in, working_register_in, bank_select_register_in} = '0;
    cmd = PCRS_CMD_NONE;
    s_axi_wstrb = 4'hF;
    {pc_m, sp_m, ul_m, hl_m, pl_m, sh_m, full_m, unf_m, flt_m, rst_m} = '0;
    fen_m = FAULT_EN_RESET;
    {miscompares, tests_run} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("reset pc", fetch_addr, RESET_VECTOR);
    chk_sp();
    rd(OFF_CONFIG);
    chk("config", rdat, 32'h1);
    rd(8'h20);
    chk("unmapped", {rdat, resp}, {32'h0, RESP_SLVERR});
    $display("reset test done");
    repeat (3) core(PCRS_CMD_FETCH, '0, 1'b0);
    for (i = 0; i < 6; i++) begin
      core(PCRS_CMD_CALL, 21'(rnd()), i[0]);
      chk_top();
    end
    core(PCRS_CMD_INT_HIGH, '0, 1'b0);
    core(PCRS_CMD_INT_LOW, '0, 1'b0);
    chk_sp();
    repeat (9) core(PCRS_CMD_RETURN, '0, 1'b1);
    chk_sp();
    wr(OFF_STACK_POINTER, 32'h0);
    unf_m = 1'b0;
    chk_sp();
    // Interrupt commands stay off while the top entries are touched
    core(PCRS_CMD_CALL, 21'(rnd()), 1'b0);
    t = {20'(rnd()), 1'b0};
    wr(OFF_TOP_LOW, {24'h0, t[7:0]});
    wr(OFF_TOP_HIGH, {24'h0, t[15:8]});
    wr(OFF_TOP_UPPER, {27'h0, t[20:16]});
    stk[sp_m] = t;
    chk_top();
    core(PCRS_CMD_RETURN, '0, 1'b0);
    $display("stack test done");
    wr(OFF_HIGH_LATCH, 32'hA5);
    wr(OFF_UPPER_LATCH, 32'h1B);
    {ul_m, hl_m} = {5'h1B, 8'hA5};
    core(PCRS_CMD_PCL_WRITE, '0, 1'b0);
    core(PCRS_CMD_CALL, 21'h000456, 1'b0);
    core(PCRS_CMD_JUMP, 21'h0001FE, 1'b0);
    core(PCRS_CMD_FETCH, '0, 1'b0);
    core(PCRS_CMD_RETURN, '0, 1'b0);
    chk_latch();
    core(PCRS_CMD_PCL_READ, '0, 1'b0);
    chk_latch();
    wr(OFF_PC_LOW, 32'hC7);
    pc_m = {ul_m, hl_m, 8'hC6};
    core(PCRS_CMD_FETCH, '0, 1'b0);
    rd(OFF_PC_LOW);
    chk("pc low", rdat, {24'h0, pc_m[7:0]});
    {ul_m, hl_m} = pc_m[20:8];
    chk_latch();
    $display("latch test done");
    wr(OFF_CONFIG, 32'h0);
    wr(OFF_STACK_POINTER, 32'h0);
    {fen_m, sp_m} = '0;
    for (i = 0; i < 32; i++) begin
      core(PCRS_CMD_SW_PUSH, '0, 1'b0);
      core(PCRS_CMD_FETCH, '0, 1'b0);
      if (i == 29) chk_sp();
    end
    chk_sp();
    chk_top();
    core(PCRS_CMD_SW_POP, '0, 1'b0);
    chk_sp();
    wr(OFF_CONFIG, 32'h1);
    wr(OFF_STACK_POINTER, 32'h1D);
    {fen_m, full_m, unf_m, sp_m} = {3'b100, 5'h1D};
    repeat (2) core(PCRS_CMD_CALL, 21'(rnd()), 1'b0);
    chk_sp();
    wr(OFF_STACK_POINTER, 32'hDF);
    sp_m = SP_FULL;
    chk_top();
    @(posedge aclk);
    dev_reset <= 1'b1;
    @(posedge aclk);
    dev_reset <= 1'b0;
    {pc_m, sp_m} = '0;
    chk_sp();
    core(PCRS_CMD_FETCH, '0, 1'b0);
    $display("overflow test done");
    wr(OFF_CONFIG, 32'h0);
    fen_m = 1'b0;
    for (i = 0; i < 300; i++) begin
      c = tbl[rnd() % 10];
      if (c == PCRS_CMD_SW_POP && sp_m == SP_EMPTY) c = PCRS_CMD_FETCH;
      core(c, 21'(rnd()), seed[4]);
      if (i % 25 == 0) chk_sp();
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule
